// >>> rtl/tcmwb_top.sv
// local-memory interface with per-port write buffers and bus fallback
//
`timescale 1ns/10ps
`include "tcmwb_params.svh"
module tcmwb_top import tcmwb_pkg::*; #(
	parameter logic [9:0] INSTRUCTION_LOCAL_MEMORY_REGION = `TCMWB_INSTRUCTION_LOCAL_MEMORY_REGION,
	parameter logic [9:0] DATA_LOCAL_MEMORY_REGION = `TCMWB_DATA_LOCAL_MEMORY_REGION
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic instruction_local_memory_enable,
	input wire logic data_local_memory_enable,
	input wire logic strict_order,
	input wire logic [4:0] instr_mem_size_cfg,
	input wire logic [4:0] data_mem_size_cfg,
	input wire logic core_req,
	input wire logic core_write,
	input wire logic core_fetch,
	input wire logic [31:0] core_addr,
	input wire logic [31:0] core_wdata,
	input wire logic [3:0] core_be,
	output logic core_ready,
	output logic [31:0] core_rdata,
	output logic core_data_abort,
	output logic core_fetch_fault,
	input wire logic core_execute,
	output logic core_prefetch_abort,
	output logic wb_empty,
	output logic bus_req,
	output logic bus_write,
	output logic [31:0] bus_addr,
	output logic [31:0] bus_wdata,
	output logic [3:0] bus_be,
	input wire logic bus_ready,
	input wire logic [31:0] bus_rdata,
	output logic instr_mem_select,
	output logic instr_mem_write_not_read,
	output logic [3:0] instr_mem_byte_write_en,
	output logic [21:2] instr_mem_word_addr,
	output logic [31:0] instr_mem_wdata,
	input wire logic [31:0] instr_mem_rdata,
	input wire logic instr_mem_wait,
	input wire logic instr_mem_read_fault,
	output logic data_mem_port0_select,
	output logic data_mem_port0_write_not_read,
	output logic [3:0] data_mem_port0_byte_write_en,
	output logic [21:3] data_mem_port0_word_addr,
	output logic [31:0] data_mem_port0_wdata,
	input wire logic [31:0] data_mem_port0_rdata,
	input wire logic data_mem_port0_wait,
	input wire logic data_port0_read_fault,
	output logic data_mem_port1_select,
	output logic data_mem_port1_write_not_read,
	output logic [3:0] data_mem_port1_byte_write_en,
	output logic [21:3] data_mem_port1_word_addr,
	output logic [31:0] data_mem_port1_wdata,
	input wire logic [31:0] data_mem_port1_rdata,
	input wire logic data_mem_port1_wait,
	input wire logic data_port1_read_fault
);

	localparam int NP = `TCMWB_NUM_PORTS;
	localparam int DP = `TCMWB_WB_DEPTH;
	localparam int WA = `TCMWB_WADDR_W;

	// ************************************************************
	// declarations
	// ************************************************************
	tcmwb_core_st_t st_reg;
	logic [1:0] port_idx_reg;
	logic [WA-1:0] req_waddr_reg;
	logic req_fetch_reg;
	logic [31:0] rdata_reg;
	logic resp_fault_reg;
	logic fetch_pend_reg;
	logic prefetch_abort_reg;

	logic in_instruction_local_memory, in_data_local_memory, cur_bus;
	logic [1:0] cur_idx;
	logic [WA-1:0] cur_waddr;
	logic [WA-1:0] imask, dmask;

	logic [NP-1:0] pt_wr_valid, pt_wr_ready, pt_rd_req, pt_blocked, pt_full_hit, pt_take_hit;
	logic [NP-1:0] pt_rd_go, pt_wr_go, pt_busy, pt_wr_done, pt_rd_done, pt_rd_fault;
	logic [WA-1:0] pt_go_addr [NP];
	logic [31:0] pt_go_data [NP];
	logic [3:0] pt_go_be [NP];
	logic [31:0] pt_rd_data [NP];
	logic [31:0] fwd_data [NP];
	logic [3:0] fwd_mask [NP];

	logic [WA-1:0] ent_addr_reg [NP][DP];
	logic [31:0] ent_data_reg [NP][DP];
	logic [3:0] ent_be_reg [NP][DP];
	logic [1:0] cnt_reg [NP];
	logic [NP-1:0] head_reg;

	logic [NP-1:0] pin_sel, pin_wnr, pin_wait, pin_fault;
	logic [3:0] pin_we [NP];
	logic [WA-1:0] pin_addr [NP];
	logic [31:0] pin_wdata [NP];
	logic [31:0] pin_rdata [NP];

	// ************************************************************
	// address decode and aliasing
	// ************************************************************
	// size inputs are static straps, so masks need no synchroniser
	assign imask = tcmwb_alias_mask(instr_mem_size_cfg, 1'b0);
	assign dmask = tcmwb_alias_mask(data_mem_size_cfg, 1'b1);

	always_comb begin
		in_instruction_local_memory = (core_addr[31:22] == INSTRUCTION_LOCAL_MEMORY_REGION) && instruction_local_memory_enable;
		in_data_local_memory = (core_addr[31:22] == DATA_LOCAL_MEMORY_REGION) && data_local_memory_enable;
		cur_bus = !in_instruction_local_memory && !in_data_local_memory;
		if (in_instruction_local_memory) begin
			cur_idx = 2'd0;
			cur_waddr = core_addr[21:2] & imask;
		end else begin
			cur_idx = core_addr[2] ? 2'd2 : 2'd1;
			cur_waddr = {1'b0, core_addr[21:3]} & dmask;
		end
	end

	// ************************************************************
	// per-port write buffer and memory sequencer
	// ************************************************************
	for (genvar p = 0; p < NP; p++) begin : g_port
		logic [1:0] pidx;
		logic push, slot_new;

		assign pidx = 2'(p);
		assign pt_wr_ready[p] = (cnt_reg[p] != 2'd2);
		assign pt_wr_valid[p] = (st_reg == C_IDLE) && core_req && core_write && !cur_bus && (cur_idx == pidx);
		assign pt_rd_req[p] = (st_reg == C_RD) && (port_idx_reg == pidx);
		assign pt_blocked[p] = strict_order && (cnt_reg[p] != 2'd0);
		assign pt_full_hit[p] = (fwd_mask[p] == `TCMWB_ALL_BYTES);
		assign pt_take_hit[p] = pt_rd_req[p] && !pt_blocked[p] && pt_full_hit[p];
		assign pt_rd_go[p] = pt_rd_req[p] && !pt_blocked[p] && !pt_full_hit[p] && !pt_busy[p];
		// a waiting read goes first unless strict ordering blocks it; otherwise drain the oldest entry
		assign pt_wr_go[p] = !pt_busy[p] && (cnt_reg[p] != 2'd0) && !(pt_rd_req[p] && !pt_blocked[p]);
		assign pt_go_addr[p] = pt_wr_go[p] ? ent_addr_reg[p][head_reg[p]] : req_waddr_reg;
		assign pt_go_data[p] = ent_data_reg[p][head_reg[p]];
		assign pt_go_be[p] = pt_wr_go[p] ? ent_be_reg[p][head_reg[p]] : `TCMWB_ALL_BYTES;
		assign push = pt_wr_valid[p] && pt_wr_ready[p];
		assign slot_new = head_reg[p] ^ (cnt_reg[p] != 2'd0);

		// oldest first so the newest bytes win
		always_comb begin
			logic sl;
			sl = head_reg[p];
			fwd_data[p] = 32'h00000000;
			fwd_mask[p] = 4'h0;
			for (int k = 0; k < DP; k++) begin
				sl = head_reg[p] ^ k[0];
				if (cnt_reg[p] > 2'(k) && ent_addr_reg[p][sl] == req_waddr_reg) begin
					fwd_data[p] = tcmwb_merge(fwd_data[p], ent_data_reg[p][sl], ent_be_reg[p][sl]);
					fwd_mask[p] = fwd_mask[p] | ent_be_reg[p][sl];
				end
			end
		end

		always_ff @(posedge sys_clk or negedge reset_n) begin
			if (!reset_n) begin
				cnt_reg[p] <= 2'd0;
				head_reg[p] <= 1'b0;
			end else begin
				if (pt_wr_done[p]) begin
					head_reg[p] <= ~head_reg[p];
				end
				unique case ({push, pt_wr_done[p]})
					2'b10: cnt_reg[p] <= cnt_reg[p] + 2'd1;
					2'b01: cnt_reg[p] <= cnt_reg[p] - 2'd1;
					default: cnt_reg[p] <= cnt_reg[p];
				endcase
			end
		end

		// payload needs no reset; occupancy tells what is live
		always_ff @(posedge sys_clk) begin
			if (push) begin
				ent_addr_reg[p][slot_new] <= cur_waddr;
				ent_data_reg[p][slot_new] <= core_wdata;
				ent_be_reg[p][slot_new] <= core_be;
			end
		end

		tcmwb_mem_seq #(.AW(WA)) u_seq (
			.sys_clk(sys_clk),
			.reset_n(reset_n),
			.go(pt_rd_go[p] || pt_wr_go[p]),
			.go_write(pt_wr_go[p]),
			.go_addr(pt_go_addr[p]),
			.go_data(pt_go_data[p]),
			.go_be(pt_go_be[p]),
			.busy(pt_busy[p]),
			.wr_done(pt_wr_done[p]),
			.rd_done(pt_rd_done[p]),
			.rd_data(pt_rd_data[p]),
			.rd_fault(pt_rd_fault[p]),
			.mem_select(pin_sel[p]),
			.mem_write_not_read(pin_wnr[p]),
			.mem_byte_write_en(pin_we[p]),
			.mem_word_addr(pin_addr[p]),
			.mem_wdata(pin_wdata[p]),
			.mem_rdata(pin_rdata[p]),
			.mem_wait(pin_wait[p]),
			.mem_read_fault(pin_fault[p])
		);
	end

	// ************************************************************
	// memory pins
	// ************************************************************
	assign instr_mem_select = pin_sel[0];
	assign instr_mem_write_not_read = pin_wnr[0];
	assign instr_mem_byte_write_en = pin_we[0];
	assign instr_mem_word_addr = pin_addr[0];
	assign instr_mem_wdata = pin_wdata[0];
	assign pin_rdata[0] = instr_mem_rdata;
	assign pin_wait[0] = instr_mem_wait;
	assign pin_fault[0] = instr_mem_read_fault;

	assign data_mem_port0_select = pin_sel[1];
	assign data_mem_port0_write_not_read = pin_wnr[1];
	assign data_mem_port0_byte_write_en = pin_we[1];
	assign data_mem_port0_word_addr = pin_addr[1][18:0];
	assign data_mem_port0_wdata = pin_wdata[1];
	assign pin_rdata[1] = data_mem_port0_rdata;
	assign pin_wait[1] = data_mem_port0_wait;
	assign pin_fault[1] = data_port0_read_fault;

	assign data_mem_port1_select = pin_sel[2];
	assign data_mem_port1_write_not_read = pin_wnr[2];
	assign data_mem_port1_byte_write_en = pin_we[2];
	assign data_mem_port1_word_addr = pin_addr[2][18:0];
	assign data_mem_port1_wdata = pin_wdata[2];
	assign pin_rdata[2] = data_mem_port1_rdata;
	assign pin_wait[2] = data_mem_port1_wait;
	assign pin_fault[2] = data_port1_read_fault;

	// ************************************************************
	// core request sequencing
	// ************************************************************
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= C_IDLE;
		end else begin
			unique case (st_reg)
				C_IDLE: begin
					if (core_req && cur_bus) begin
						st_reg <= C_BUS;
					end else if (core_req && !core_write) begin
						st_reg <= C_RD;
					end
				end
				C_RD: begin
					if (pt_take_hit[port_idx_reg]) begin
						st_reg <= C_RESP;
					end else if (pt_rd_go[port_idx_reg]) begin
						st_reg <= C_RDW;
					end
				end
				C_RDW: if (pt_rd_done[port_idx_reg]) st_reg <= C_RESP;
				C_BUS: if (bus_ready) st_reg <= C_RESP;
				C_RESP: st_reg <= C_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			port_idx_reg <= 2'd0;
			req_waddr_reg <= '0;
			req_fetch_reg <= 1'b0;
		end else if (st_reg == C_IDLE && core_req) begin
			port_idx_reg <= cur_idx;
			req_waddr_reg <= cur_waddr;
			req_fetch_reg <= core_fetch;
		end
	end

	// returned word, merged with any newer buffered bytes
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_reg <= 32'h00000000;
			resp_fault_reg <= 1'b0;
		end else if (st_reg == C_RD && pt_take_hit[port_idx_reg]) begin
			rdata_reg <= fwd_data[port_idx_reg];
			resp_fault_reg <= 1'b0;
		end else if (st_reg == C_RDW && pt_rd_done[port_idx_reg]) begin
			rdata_reg <= tcmwb_merge(pt_rd_data[port_idx_reg], fwd_data[port_idx_reg], fwd_mask[port_idx_reg]);
			resp_fault_reg <= pt_rd_fault[port_idx_reg];
		end else if (st_reg == C_BUS && bus_ready) begin
			rdata_reg <= bus_rdata;
			resp_fault_reg <= 1'b0;
		end
	end

	// ************************************************************
	// system bus fallback
	// ************************************************************
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_req <= 1'b0;
			bus_write <= 1'b0;
			bus_addr <= 32'h00000000;
			bus_wdata <= 32'h00000000;
			bus_be <= 4'h0;
		end else if (st_reg == C_IDLE && core_req && cur_bus) begin
			bus_req <= 1'b1;
			bus_write <= core_write;
			bus_addr <= core_addr;
			bus_wdata <= core_wdata;
			bus_be <= core_be;
		end else if (st_reg == C_BUS && bus_ready) begin
			bus_req <= 1'b0;
		end
	end

	// ************************************************************
	// aborts
	// ************************************************************
	// a faulting fetch may be discarded unexecuted, so hold it pending
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			fetch_pend_reg <= 1'b0;
			prefetch_abort_reg <= 1'b0;
		end else begin
			prefetch_abort_reg <= core_execute && fetch_pend_reg;
			if (st_reg == C_RESP && req_fetch_reg) begin
				fetch_pend_reg <= resp_fault_reg;
			end else if (core_execute) begin
				fetch_pend_reg <= 1'b0;
			end
		end
	end

	// ************************************************************
	// core-facing outputs
	// ************************************************************
	assign core_ready = (st_reg == C_RESP) || (pt_wr_valid[cur_idx] && pt_wr_ready[cur_idx]);
	assign core_rdata = rdata_reg;
	assign core_data_abort = (st_reg == C_RESP) && resp_fault_reg && !req_fetch_reg;
	assign core_fetch_fault = (st_reg == C_RESP) && resp_fault_reg && req_fetch_reg;
	assign core_prefetch_abort = prefetch_abort_reg;
	assign wb_empty = (cnt_reg[0] == 2'd0) && (cnt_reg[1] == 2'd0) && (cnt_reg[2] == 2'd0) && !(|pt_busy);

endmodule

// >>> rtl/tcmwb_params.svh
// constants for the local-memory write buffer interface
//
// Functional notes
// - each local memory port owns a two-entry write buffer of address/data pairs.
// - buffered writes leave when pushed by another write or when no read waits.
// - a write into a buffer with a free entry completes in one cycle.
// - a write to a full buffer stalls the core until an entry drains.
// - reads hitting buffered bytes get buffered data; other reads may bypass writes.
// - with strict ordering set, reads stall until the buffer is empty.
// - size code 1..13 means 1KB..4MB in powers of two; others reserved.
// - size inputs fold aliased addresses; integrator sets the real memory size.
// - one fault input per memory port, sampled only with read data.
// - a faulting data read from either memory raises a data abort.
// - a faulting fetch raises a prefetch abort only when executed.
// - full buffer hit makes no memory request, ignores fault; partial hit passes it.
// - memory may stretch a read with wait; data follows wait release, access held.
// - write data goes out with the address and holds through wait cycles.
// - each data port drives word address bits [21:3]; ports alternate on words.
// - a four-bit byte write enable steers byte and halfword writes.
// - instruction memory space goes to the local memory only while its enable is set.
// - data memory space goes local while its enable is set; drain before disabling.
`ifndef TCMWB_PARAMS_SVH
`define TCMWB_PARAMS_SVH

// ************************************************************
// sizes and address map
// ************************************************************
`define TCMWB_NUM_PORTS 3
`define TCMWB_WB_DEPTH 2
`define TCMWB_WADDR_W 20
`define TCMWB_INSTRUCTION_LOCAL_MEMORY_REGION 10'h000
`define TCMWB_DATA_LOCAL_MEMORY_REGION 10'h008
`define TCMWB_SIZE_MIN 5'h01
`define TCMWB_SIZE_MAX 5'h0d
`define TCMWB_SIZE_BASE_BITS 5'h07
`define TCMWB_ALL_BYTES 4'hf

`endif

// >>> rtl/tcmwb_pkg.sv
// types and helpers shared by the write buffer interface
`include "tcmwb_params.svh"
package tcmwb_pkg;

	typedef enum logic [2:0] {C_IDLE, C_RD, C_RDW, C_BUS, C_RESP} tcmwb_core_st_t;
	typedef enum logic [1:0] {S_IDLE, S_ACC, S_DATA} tcmwb_seq_st_t;

	// byte-lane overlay of new onto old
	function automatic logic [31:0] tcmwb_merge(input logic [31:0] old_d, input logic [31:0] new_d,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_d;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// word-address mask for a size code; half for a data port
	function automatic logic [19:0] tcmwb_alias_mask(input logic [4:0] code, input logic half);
		logic [4:0] bits;
		bits = code + `TCMWB_SIZE_BASE_BITS - {4'h0, half};
		if (code < `TCMWB_SIZE_MIN || code > `TCMWB_SIZE_MAX) begin
			return 20'h00000;
		end
		return ~(20'hfffff << bits);
	endfunction

endpackage

// >>> rtl/tcmwb_mem_seq.sv
// single-port memory sequencer with wait-state handling
`timescale 1ns/10ps
module tcmwb_mem_seq import tcmwb_pkg::*; #(
	parameter int AW = 20
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic go,
	input wire logic go_write,
	input wire logic [AW-1:0] go_addr,
	input wire logic [31:0] go_data,
	input wire logic [3:0] go_be,
	output logic busy,
	output logic wr_done,
	output logic rd_done,
	output logic [31:0] rd_data,
	output logic rd_fault,
	output logic mem_select,
	output logic mem_write_not_read,
	output logic [3:0] mem_byte_write_en,
	output logic [AW-1:0] mem_word_addr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_wait,
	input wire logic mem_read_fault
);

	tcmwb_seq_st_t st_reg;

	assign busy = (st_reg != S_IDLE);
	assign wr_done = (st_reg == S_ACC) && mem_write_not_read && !mem_wait;

	// ************************************************************
	// access sequencing
	// ************************************************************
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= S_IDLE;
		end else begin
			unique case (st_reg)
				S_IDLE: if (go) st_reg <= S_ACC;
				S_ACC: if (!mem_wait) st_reg <= mem_write_not_read ? S_IDLE : S_DATA;
				S_DATA: st_reg <= S_IDLE;
			endcase
		end
	end

	// pins stay put while wait is high
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mem_select <= 1'b0;
			mem_write_not_read <= 1'b0;
			mem_byte_write_en <= 4'h0;
			mem_word_addr <= '0;
			mem_wdata <= 32'h00000000;
		end else if (st_reg == S_IDLE && go) begin
			mem_select <= 1'b1;
			mem_write_not_read <= go_write;
			mem_byte_write_en <= go_write ? go_be : 4'h0;
			mem_word_addr <= go_addr;
			mem_wdata <= go_data;
		end else if (st_reg == S_ACC && !mem_wait) begin
			mem_select <= 1'b0;
			mem_byte_write_en <= 4'h0;
		end
	end

	// fault only looked at in the read data cycle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_done <= 1'b0;
			rd_data <= 32'h00000000;
			rd_fault <= 1'b0;
		end else begin
			rd_done <= (st_reg == S_DATA);
			if (st_reg == S_DATA) begin
				rd_data <= mem_rdata;
				rd_fault <= mem_read_fault;
			end
		end
	end

endmodule

// >>> tb/tcmwb_mem_model.sv
// behavioural single-port local memory with wait states and fault injection
`timescale 1ns/10ps
module tcmwb_mem_model (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic sel,
	input wire logic wnr,
	input wire logic [3:0] be,
	input wire logic [7:0] addr,
	input wire logic [31:0] wd,
	input wire logic [2:0] nwait,
	input wire logic fault_on,
	output logic wt,
	output logic [31:0] rd,
	output logic flt
);
	logic [31:0] mem [256]; // plain storage, reads have no side effects
	logic [31:0] last;
	logic [2:0] wcnt;
	logic dcyc;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 32'hc0de0000 | i;
		end
	end
	assign wt = sel && wcnt < nwait;
	// outside the data cycle: junk data and a false fault, to catch late sampling
	assign rd = dcyc ? last : ~last;
	assign flt = dcyc ? fault_on : 1'b1;
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wcnt <= 3'h0;
			dcyc <= 1'b0;
			last <= 32'h0;
		end else begin
			wcnt <= wt ? wcnt + 3'h1 : 3'h0;
			dcyc <= sel && !wt && !wnr;
			if (sel && !wt && !wnr) begin
				last <= mem[addr];
			end
			for (int i = 0; i < 4; i++) begin
				if (sel && !wt && wnr && be[i]) begin
					mem[addr][i*8 +: 8] <= wd[i*8 +: 8];
				end
			end
		end
	end
endmodule

// >>> tb/tcmwb_chk.sv
// port assertions for the local-memory write buffer interface
`timescale 1ns/10ps
module tcmwb_chk #(
	parameter logic [9:0] INSTRUCTION_LOCAL_MEMORY_REGION = 10'h000
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic instruction_local_memory_enable,
	input wire logic strict_order,
	input wire logic core_req,
	input wire logic core_write,
	input wire logic core_fetch,
	input wire logic [31:0] core_addr,
	input wire logic core_ready,
	input wire logic core_data_abort,
	input wire logic core_fetch_fault,
	input wire logic core_execute,
	input wire logic core_prefetch_abort,
	input wire logic wb_empty,
	input wire logic bus_req,
	input wire logic instr_mem_select,
	input wire logic instr_mem_write_not_read,
	input wire logic [3:0] instr_mem_byte_write_en,
	input wire logic [21:2] instr_mem_word_addr,
	input wire logic [31:0] instr_mem_wdata,
	input wire logic instr_mem_wait,
	input wire logic instr_mem_read_fault
);
	logic i_loc;
	assign i_loc = instruction_local_memory_enable && core_addr[31:22] == INSTRUCTION_LOCAL_MEMORY_REGION;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence i_rd_done;
		instr_mem_select && !instr_mem_write_not_read && !instr_mem_wait;
	endsequence
	sequence fetch_bad;
		core_ready && core_fetch && core_fetch_fault;
	endsequence
	// ****************
	// assertions
	// ****************
	write_single_a: assert property (core_req && core_write && i_loc && wb_empty |-> core_ready)
		else $error("free buffer did not take write at once");
	instr_hold_a: assert property (
		instr_mem_select && instr_mem_wait |=> instr_mem_select && $stable(instr_mem_word_addr)
		&& $stable(instr_mem_wdata) && $stable(instr_mem_byte_write_en) && $stable(instr_mem_write_not_read))
		else $error("access moved during wait");
	select_gap_a: assert property (instr_mem_select && !instr_mem_wait |=> !instr_mem_select)
		else $error("select held past completion");
	read_abort_a: assert property (
		i_rd_done ##1 instr_mem_read_fault |-> ##2 core_ready && (core_fetch ? core_fetch_fault : core_data_abort))
		else $error("faulting read gave no abort");
	abort_cause_a: assert property (core_data_abort |-> core_ready && !core_write && !core_fetch)
		else $error("abort outside a data read answer");
	pref_abort_a: assert property (fetch_bad ##1 core_execute |=> core_prefetch_abort)
		else $error("executed bad fetch not aborted");
	pref_cause_a: assert property (core_prefetch_abort |-> $past(core_execute))
		else $error("prefetch abort without execute");
	strict_block_a: assert property (
		strict_order && core_req && !core_write && i_loc && instr_mem_select && instr_mem_write_not_read
		|-> !core_ready)
		else $error("read answered while strict drain pending");
	bus_route_a: assert property (bus_req |-> !i_loc)
		else $error("enabled local access went to bus");
endmodule
bind tcmwb_top tcmwb_chk #(.INSTRUCTION_LOCAL_MEMORY_REGION(INSTRUCTION_LOCAL_MEMORY_REGION)) chk (.*);

// >>> tb/tcmwb_top_tb.sv
// self-checking bench for the local-memory write buffer interface
`timescale 1ns/10ps
module tcmwb_top_tb;
	`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
		$display("Error %0t: got %h expected %h", $time, a, b); end end
	logic sys_clk, reset_n, instruction_local_memory_enable, data_local_memory_enable, strict_order, core_req, core_write, core_fetch, core_execute;
	logic core_ready, core_data_abort, core_fetch_fault, core_prefetch_abort, wb_empty, bus_req, bus_write, bus_ready;
	logic instr_mem_select, instr_mem_write_not_read, instr_mem_wait, instr_mem_read_fault;
	logic data_mem_port0_select, data_mem_port0_write_not_read, data_mem_port0_wait, data_port0_read_fault;
	logic data_mem_port1_select, data_mem_port1_write_not_read, data_mem_port1_wait, data_port1_read_fault;
	logic [4:0] instr_mem_size_cfg, data_mem_size_cfg;
	logic [3:0] core_be, bus_be, instr_mem_byte_write_en, data_mem_port0_byte_write_en, data_mem_port1_byte_write_en;
	logic [31:0] core_addr, core_wdata, core_rdata, bus_addr, bus_wdata, bus_rdata, instr_mem_wdata, instr_mem_rdata;
	logic [31:0] data_mem_port0_wdata, data_mem_port0_rdata, data_mem_port1_wdata, data_mem_port1_rdata, rdat;
	logic [21:2] instr_mem_word_addr;
	logic [21:3] data_mem_port0_word_addr, data_mem_port1_word_addr;
	logic [2:0] iw, dw;
	logic ifo, rab, rff;
	int n, m, cyc, miscompares, checks_done;
	tcmwb_top dut (.*);
	tcmwb_mem_model im (.sys_clk(sys_clk), .reset_n(reset_n), .sel(instr_mem_select), .wnr(instr_mem_write_not_read),
		.be(instr_mem_byte_write_en), .addr(instr_mem_word_addr[9:2]), .wd(instr_mem_wdata), .nwait(iw),
		.fault_on(ifo), .wt(instr_mem_wait), .rd(instr_mem_rdata), .flt(instr_mem_read_fault));
	tcmwb_mem_model d0 (.sys_clk(sys_clk), .reset_n(reset_n), .sel(data_mem_port0_select),
		.wnr(data_mem_port0_write_not_read), .be(data_mem_port0_byte_write_en), .addr(data_mem_port0_word_addr[10:3]),
		.wd(data_mem_port0_wdata), .nwait(dw), .fault_on(1'b0), .wt(data_mem_port0_wait),
		.rd(data_mem_port0_rdata), .flt(data_port0_read_fault));
	tcmwb_mem_model d1 (.sys_clk(sys_clk), .reset_n(reset_n), .sel(data_mem_port1_select),
		.wnr(data_mem_port1_write_not_read), .be(data_mem_port1_byte_write_en), .addr(data_mem_port1_word_addr[10:3]),
		.wd(data_mem_port1_wdata), .nwait(dw), .fault_on(1'b0), .wt(data_mem_port1_wait),
		.rd(data_mem_port1_rdata), .flt(data_port1_read_fault));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// bus slave answers after one cycle, then shows junk
	always @(posedge sys_clk) begin
		bus_ready <= bus_req && !bus_ready;
		bus_rdata <= (bus_req && !bus_ready) ? 32'h5a5a0f0f : 32'ha5a5f0f0;
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// keep holds the request up for a back-to-back follower
	task automatic acc(input logic w, f, input logic [31:0] a, d, input logic [3:0] b, input logic keep);
		core_req <= 1'b1;
		core_write <= w;
		core_fetch <= f;
		core_addr <= a;
		core_wdata <= d;
		core_be <= b;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (core_ready !== 1'b1 && n < 200);
		`CHK(core_ready, 1'b1)
		rdat = core_rdata;
		rab = core_data_abort;
		rff = core_fetch_fault;
		@(posedge sys_clk);
		if (!keep) begin
			core_req <= 1'b0;
		end
	endtask
	task automatic drain();
		int i;
		i = 0;
		do begin
			@(negedge sys_clk);
			i++;
		end while (wb_empty !== 1'b1 && i < 100);
		`CHK(wb_empty, 1'b1)
		@(posedge sys_clk);
	endtask
	task automatic exec_chk(input logic e);
		core_execute <= 1'b1;
		@(posedge sys_clk);
		core_execute <= 1'b0;
		@(negedge sys_clk);
		`CHK(core_prefetch_abort, e)
		@(posedge sys_clk);
	endtask
	initial begin
		reset_n = 1'b0;
		{instruction_local_memory_enable, data_local_memory_enable, strict_order, core_req, core_write, core_fetch, core_execute} = 7'h60;
		{core_addr, core_wdata, core_be, iw, dw, ifo} = 0;
		instr_mem_size_cfg = 5'h0d;
		data_mem_size_cfg = 5'h01;
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		iw <= 3'h3;
		acc(1, 0, 32'h10, 32'h1111aaaa, 4'hf, 1);
		`CHK(n, 1)
		acc(1, 0, 32'h14, 32'h2222bbbb, 4'hf, 1);
		`CHK(n, 1)
		acc(1, 0, 32'h18, 32'h3333cccc, 4'hf, 0);
		`CHK(n > 1, 1'b1)
		drain();
		acc(0, 0, 32'h18, 0, 4'hf, 1);
		`CHK(rdat, 32'h3333cccc)
		iw <= 3'h0;
		acc(1, 0, 32'h20, 32'h0000aaaa, 4'hf, 1);
		acc(1, 0, 32'h20, 32'h0000bbbb, 4'hf, 0);
		drain();
		acc(0, 0, 32'h20, 0, 4'hf, 1);
		`CHK(rdat, 32'h0000bbbb)
		ifo <= 1'b1;
		acc(1, 0, 32'h30, 32'h12345678, 4'hf, 1);
		acc(0, 0, 32'h30, 0, 4'hf, 0);
		`CHK(rdat, 32'h12345678)
		`CHK(rab, 1'b0)
		drain();
		// first write holds the sequencer so the byte write is still buffered at the read
		acc(1, 0, 32'h3c, 32'h0, 4'hf, 1);
		acc(1, 0, 32'h34, 32'h000000ab, 4'h1, 1);
		acc(0, 0, 32'h34, 0, 4'hf, 0);
		`CHK(rdat, 32'hc0de00ab)
		`CHK(rab, 1'b1)
		drain();
		acc(0, 0, 32'h34, 0, 4'hf, 1);
		`CHK(rdat, 32'hc0de00ab)
		acc(0, 1, 32'h44, 0, 4'hf, 0);
		`CHK(rff, 1'b1)
		`CHK(rab, 1'b0)
		exec_chk(1'b1);
		ifo <= 1'b0;
		acc(0, 1, 32'h48, 0, 4'hf, 0);
		`CHK(rdat, 32'hc0de0012)
		exec_chk(1'b0);
		iw <= 3'h2;
		// second entry stays pending while the read goes ahead of it
		repeat (2) acc(1, 0, 32'h58, 32'h0, 4'hf, 1);
		acc(0, 0, 32'h5c, 0, 4'hf, 0);
		`CHK(rdat, 32'hc0de0017)
		m = n;
		drain();
		strict_order <= 1'b1;
		repeat (2) acc(1, 0, 32'h50, 32'h0, 4'hf, 1);
		acc(0, 0, 32'h54, 0, 4'hf, 0);
		`CHK(n > m, 1'b1)
		`CHK(rdat, 32'hc0de0015)
		drain();
		strict_order <= 1'b0;
		dw <= 3'h1;
		acc(1, 0, 32'h02000000, 32'hd0d0d0d0, 4'hf, 1);
		acc(1, 0, 32'h02000004, 32'hd1d1d1d1, 4'hf, 1);
		acc(1, 0, 32'h02000400, 32'hd2d2d2d2, 4'hf, 0);
		drain();
		acc(0, 0, 32'h02000000, 0, 4'hf, 1);
		`CHK(rdat, 32'hd2d2d2d2)
		acc(0, 0, 32'h02000004, 0, 4'hf, 1);
		`CHK(rdat, 32'hd1d1d1d1)
		instruction_local_memory_enable <= 1'b0;
		acc(0, 0, 32'h10, 0, 4'hf, 1);
		`CHK(rdat, 32'h5a5a0f0f)
		instruction_local_memory_enable <= 1'b1;
		data_local_memory_enable <= 1'b0;
		acc(0, 0, 32'h02000000, 0, 4'hf, 0);
		`CHK(rdat, 32'h5a5a0f0f)
		end_sim();
	end
endmodule
